/* File: rtl/wake_reset_exit_sequencer.sv */
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ns
// Contract
// R1: Waking from primary idle, or to external clock or RC, costs only cpu_wake_delay.
// R2: Crystal targets from timer1, slow osc or sleep wait startup, then primary ready flag.
// R3: PLL target after stopped oscillator waits startup plus PLL lock interval.
// R4: Fast internal target waits settle delay and stable flag, none if already fast.
// R5: Ready flag is primary for crystal and PLL, stable for fast, none for slow.
// R6: The slow internal source is the 31 kHz oscillator.
// R7: cpu_wake_delay always applies and runs in parallel with other delays.
// R8: After a reset the fast oscillator frequency selection defaults to 1 MHz.
// R9: Fast internal category covers the 8 MHz source and all postscaled rates.
// R10: Execution continues while the fast oscillator settle delay elapses.
// R11: Eight reset causes are told apart.
// R12: Lower five bits of reset_cause_control each flag a reset event.
// R13: Hardware only clears flags on events; software sets them again. Here hardware also sets the WDT and PWRDN flags, which software cannot write.
// R14: All flags together identify the latest reset type.
// R15: reset_cause_control also holds interrupt split and undervoltage enable bits.
// R16: Bit layout, access and reset values of reset_cause_control are fixed.
// R17: sw_undervolt_reset_enable enables undervoltage reset when configuration permits.
// R18: Reset instruction flag reads 0 after that reset; software sets it after undervoltage.
module wake_reset_exit_sequencer
  import wake_seq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [2:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_master_clear_n,
  input wire logic i_pm_mode,
  input wire src_before_t i_src_before,
  input wire src_after_t i_src_after,
  input wire logic i_por,
  input wire logic i_wdt,
  input wire logic i_bor,
  input wire logic i_rst_instr,
  input wire logic i_stack_full,
  input wire logic i_stack_under,
  input wire logic i_sleep_instr,
  input wire logic i_clrwdt,
  input wire logic i_sbor_allowed,
  output logic o_cpu_run,
  output logic o_primary_clock_ready,
  output logic o_internal_osc_stable,
  output logic o_irq_level_split,
  output logic o_undervolt_reset_en,
  output logic [2:0] o_fast_osc_freq,
  output logic o_irq
);
  typedef enum logic {SEQ_EXEC, SEQ_EXIT} seq_t;

  typedef struct packed {
    seq_t seq;
    logic [7:0] rcc;
    logic [2:0] freq;
    logic primary_clock_ready_flag;
    logic internal_osc_stable_flag;
    logic [1:0] pend;
    logic hold;
    logic [STAT_W-1:0] stat;
    logic [STAT_W-1:0] mask;
    cause_t cause;
    logic [2:0] pin;
    logic pin_lvl;
    logic ack;
    logic [STAT_W-1:0] rdata;
  } st_t;

  st_t q;
  st_t d;
  logic [7:0] ev;
  logic master_clear_pin_evt;
  logic wake;
  logic xtal;
  logic pll;
  logic no_wait;
  logic [TMR_W-1:0] osc_cyc;
  logic cpu_busy;
  logic osc_busy;
  logic req;
  logic acc;
  logic [31:0] wmask;

  // Byte-lane merge of a bus write into an existing register value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] be_bits);
    merge = (old & ~be_bits) | (nw & be_bits);
  endfunction

  // Lowest cause index wins, so a power-on event masks anything coincident.
  function automatic cause_t first_cause(input logic [7:0] e);
    first_cause = CAUSE_POR;
    for (int i = 7; i >= 0; i--) begin
      if (e[i]) begin
        first_cause = cause_t'(3'(i));
      end
    end
  endfunction

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{i_byteenable[b]}};
    end
  end

  // The pin counts only once the second and third stages agree.
  assign master_clear_pin_evt = q.pin_lvl & (q.pin[1] == q.pin[2]) & ~q.pin[2];

  always_comb begin
    ev = '0;
    ev[CAUSE_POR] = i_por;
    ev[CAUSE_MASTER_CLEAR_PIN_RUN] = master_clear_pin_evt & ~i_pm_mode;
    ev[CAUSE_MASTER_CLEAR_PIN_PM] = master_clear_pin_evt & i_pm_mode;
    ev[CAUSE_WDT] = i_wdt & ~i_pm_mode;
    ev[CAUSE_BOR] = i_bor;
    ev[CAUSE_INSTR] = i_rst_instr;
    ev[CAUSE_STK_FULL] = i_stack_full;
    ev[CAUSE_STK_UNDER] = i_stack_under;
  end

  // A watchdog time-out in a power-managed mode wakes the core but is not a reset cause.
  assign wake = ((|ev) | i_wdt) & i_pm_mode & (q.seq == SEQ_EXEC);
  assign xtal = (i_src_after == AFT_LP) | (i_src_after == AFT_XT) | (i_src_after == AFT_HS);
  assign pll = (i_src_after == AFT_PLL);

  // Oscillator wait chosen from the sources before and after wake-up.
  always_comb begin
    osc_cyc = '0;
    if (i_src_before != BEF_PRIMARY_IDLE_MODE) begin
      if (xtal) begin
        osc_cyc = OSC_STARTUP_CYC; // R2
      end else if (pll) begin
        osc_cyc = OSC_STARTUP_CYC + PLL_LOCK_CYC; // R3
      end else if (i_src_after == AFT_FAST && i_src_before != BEF_FAST) begin
        osc_cyc = OSC_SETTLE_CYC; // R4 R9
      end
    end
  end
  assign no_wait = (osc_cyc == '0); // R1 R6

  // Both timers load on the same edge so the CPU delay overlaps the oscillator wait.
  delay_timer #(
    .W(TMR_W)
  ) u_cpu_tmr (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_load(wake),
    .i_count(CPU_WAKE_CYC), // R7
    .o_busy(cpu_busy)
  );

  delay_timer #(
    .W(TMR_W)
  ) u_osc_tmr (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_load(wake),
    .i_count(osc_cyc),
    .o_busy(osc_busy)
  );

  assign req = i_read | i_write;
  assign acc = req & q.ack;

  always_comb begin
    d = q;
    d.pin = {q.pin[1:0], i_master_clear_n};
    if (q.pin[1] == q.pin[2]) begin
      d.pin_lvl = q.pin[2];
    end

    // Bus: the first cycle fetches read data, the second completes.
    d.ack = req & ~q.ack;
    if (req & ~q.ack) begin
      case (i_address)
        OFS_RCC: d.rdata = STAT_W'(q.rcc);
        OFS_STAT: d.rdata = q.stat;
        OFS_MASK: d.rdata = q.mask;
        OFS_OSC: d.rdata = STAT_W'({q.freq, q.primary_clock_ready_flag, q.internal_osc_stable_flag, 2'b00});
        OFS_CAUSE: d.rdata = STAT_W'(q.cause);
        default: d.rdata = '0;
      endcase
    end
    if (acc & i_write) begin
      case (i_address)
        OFS_RCC: begin
          d.rcc = 8'(merge(32'(q.rcc), i_writedata, wmask)); // R15
          d.rcc = (q.rcc & ~RCC_WR_MASK) | (d.rcc & RCC_WR_MASK); // R13 R16
        end
        OFS_MASK: d.mask = STAT_W'(merge(32'(q.mask), i_writedata, wmask));
        OFS_OSC: d.freq = 3'(merge(32'(q.freq), i_writedata >> OSC_FREQ_LSB,
                                   wmask >> OSC_FREQ_LSB));
        default: d.rcc = q.rcc;
      endcase
    end
    if (acc & i_read & (i_address == OFS_STAT)) begin
      d.stat = '0;
    end

    // Hardware events are applied after software so they win a same-cycle write.
    if (|ev) begin
      d.cause = first_cause(ev); // R11 R14
      d.freq = FREQ_RST; // R8
    end
    d.stat[7:0] = d.stat[7:0] | ev;
    if (i_sleep_instr) begin
      d.rcc[RCC_PWRDN] = 1'b0;
      d.rcc[RCC_WDT] = 1'b1;
    end
    if (i_clrwdt) begin
      d.rcc[RCC_PWRDN] = 1'b1;
      d.rcc[RCC_WDT] = 1'b1;
    end
    if (ev[CAUSE_WDT]) begin
      d.rcc[RCC_WDT] = 1'b0; // R12
    end
    if (ev[CAUSE_INSTR]) begin
      d.rcc[RCC_INSTR] = 1'b0; // R18
    end
    if (ev[CAUSE_BOR]) begin
      d.rcc[RCC_BOR] = 1'b0; // R12
      d.rcc[RCC_INSTR] = 1'b0; // R18
    end
    if (ev[CAUSE_POR]) begin
      d.rcc[RCC_POR] = 1'b0; // R12 R13
      d.rcc[RCC_BOR] = 1'b0;
      d.rcc[RCC_INSTR] = 1'b1;
      d.rcc[RCC_WDT] = 1'b1;
      d.rcc[RCC_PWRDN] = 1'b1;
    end
    d.rcc[5] = 1'b0;

    // Ready flags rise when the oscillator wait ends, even if the CPU already runs.
    if ((|q.pend) & ~osc_busy) begin
      d.primary_clock_ready_flag = q.primary_clock_ready_flag | q.pend[1];
      d.internal_osc_stable_flag = q.internal_osc_stable_flag | q.pend[0];
      d.pend = '0;
      d.stat[ST_PRIMARY_CLOCK_READY_FLAG] = d.stat[ST_PRIMARY_CLOCK_READY_FLAG] | q.pend[1];
      d.stat[ST_INTERNAL_OSC_STABLE_FLAG] = d.stat[ST_INTERNAL_OSC_STABLE_FLAG] | q.pend[0];
    end

    case (q.seq)
      SEQ_EXEC: begin
        if (wake) begin
          d.seq = SEQ_EXIT;
          d.primary_clock_ready_flag = (xtal | pll) & no_wait & q.primary_clock_ready_flag; // R5
          d.internal_osc_stable_flag = (i_src_after == AFT_FAST) & no_wait & q.internal_osc_stable_flag; // R5
          if (no_wait) begin
            d.primary_clock_ready_flag = (xtal | pll); // R1 R5
            d.internal_osc_stable_flag = (i_src_after == AFT_FAST);
          end
          d.pend = {xtal | pll, i_src_after == AFT_FAST} & {2{~no_wait}};
          d.hold = xtal | pll; // R10
        end
      end
      SEQ_EXIT: begin
        if (~cpu_busy & (~osc_busy | ~q.hold)) begin // R7 R10
          d.seq = SEQ_EXEC;
          d.stat[ST_EXIT] = 1'b1;
        end
      end
      default: d.seq = SEQ_EXEC;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      q <= '0;
      q.seq <= SEQ_EXEC;
      q.rcc <= RCC_RST; // R16
      q.freq <= FREQ_RST; // R8
      q.cause <= CAUSE_POR;
      q.pin <= 3'h7;
      q.pin_lvl <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_readdata = 32'(q.rdata);
  assign o_waitrequest = req & ~q.ack;
  assign o_cpu_run = (q.seq == SEQ_EXEC);
  assign o_primary_clock_ready = q.primary_clock_ready_flag;
  assign o_internal_osc_stable = q.internal_osc_stable_flag;
  assign o_irq_level_split = q.rcc[RCC_SPLIT]; // R15
  assign o_undervolt_reset_en = q.rcc[RCC_SBOR] & i_sbor_allowed; // R17
  assign o_fast_osc_freq = q.freq;
  assign o_irq = |(q.stat & q.mask);
endmodule

/* File: inc/wake_seq_pkg.sv */
package wake_seq_pkg;
  localparam int CLK_MHZ = 50;
  localparam int CPU_WAKE_DELAY_NS = 2000;
  localparam int OSC_STARTUP_NS = 20000;
  localparam int PLL_LOCK_NS = 40000;
  localparam int OSC_SETTLE_NS = 1000;
  localparam int TMR_W = 12;
  localparam logic [TMR_W-1:0] CPU_WAKE_CYC =
    TMR_W'((CPU_WAKE_DELAY_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] OSC_STARTUP_CYC =
    TMR_W'((OSC_STARTUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] PLL_LOCK_CYC =
    TMR_W'((PLL_LOCK_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] OSC_SETTLE_CYC =
    TMR_W'((OSC_SETTLE_NS * CLK_MHZ + 999) / 1000);

  // Word offsets on the register bus.
  localparam logic [2:0] OFS_RCC = 3'h0;
  localparam logic [2:0] OFS_STAT = 3'h1;
  localparam logic [2:0] OFS_MASK = 3'h2;
  localparam logic [2:0] OFS_OSC = 3'h3;
  localparam logic [2:0] OFS_CAUSE = 3'h4;

  // Fields of reset_cause_control.
  localparam int RCC_SPLIT = 7;
  localparam int RCC_SBOR = 6;
  localparam int RCC_INSTR = 4;
  localparam int RCC_WDT = 3;
  localparam int RCC_PWRDN = 2;
  localparam int RCC_POR = 1;
  localparam int RCC_BOR = 0;
  localparam logic [7:0] RCC_RST = 8'h5c;
  localparam logic [7:0] RCC_WR_MASK = 8'hd3;

  // Fields of osc_control.
  localparam int OSC_FREQ_LSB = 4;
  localparam int OSC_PRIMARY_CLOCK_READY_FLAG_BIT = 3;
  localparam int OSC_INTERNAL_OSC_STABLE_FLAG_BIT = 2;
  localparam logic [2:0] FREQ_RST = 3'h4;

  // Interrupt status layout: bits 0..7 follow cause_t.
  localparam int ST_PRIMARY_CLOCK_READY_FLAG = 8;
  localparam int ST_INTERNAL_OSC_STABLE_FLAG = 9;
  localparam int ST_EXIT = 10;
  localparam int STAT_W = 11;

  typedef enum logic [2:0] {
    BEF_PRIMARY_IDLE_MODE, BEF_TIMER1, BEF_SLOW, BEF_FAST, BEF_SLEEP
  } src_before_t;
  typedef enum logic [2:0] {
    AFT_LP, AFT_XT, AFT_HS, AFT_PLL, AFT_EXT, AFT_RC, AFT_SLOW, AFT_FAST
  } src_after_t;
  typedef enum logic [2:0] {
    CAUSE_POR, CAUSE_MASTER_CLEAR_PIN_RUN, CAUSE_MASTER_CLEAR_PIN_PM, CAUSE_WDT,
    CAUSE_BOR, CAUSE_INSTR, CAUSE_STK_FULL, CAUSE_STK_UNDER
  } cause_t;
endpackage

/* File: rtl/delay_timer.sv */
`timescale 1ns/1ns
module delay_timer #(
  parameter int W = 12
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic o_busy
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_t;

  tmr_t q;
  tmr_t d;

  // A load of N keeps the timer busy for exactly N cycles.
  always_comb begin
    d = q;
    if (i_load) begin
      d.cnt = i_count;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - W'(1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_busy = (q.cnt != '0);
endmodule

/* File: bench/wake_seq_checker.sv */
`timescale 1ns/1ns
module wake_seq_checker
  import wake_seq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [2:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic i_pm_mode,
  input wire src_after_t i_src_after,
  input wire logic i_por,
  input wire logic i_wdt,
  input wire logic i_bor,
  input wire logic i_rst_instr,
  input wire logic i_stack_full,
  input wire logic i_stack_under,
  input wire logic i_sbor_allowed,
  input wire logic o_cpu_run,
  input wire logic o_primary_clock_ready,
  input wire logic o_internal_osc_stable,
  input wire logic o_irq_level_split,
  input wire logic o_undervolt_reset_en,
  input wire logic [2:0] o_fast_osc_freq,
  input wire logic o_irq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  wire logic ev = i_por | i_bor | i_rst_instr | i_stack_full | i_stack_under;
  wire logic wr_rcc = i_write & ~o_waitrequest & (i_address == OFS_RCC) & i_byteenable[0];
  chk_wait_once: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("waitrequest held past one cycle");
  chk_unmapped_zero: assert property (i_read && !o_waitrequest && i_address > 3'h4 |->
    o_readdata == 32'h0) else $error("unmapped read not zero");
  chk_split_write: assert property (wr_rcc |=>
    o_irq_level_split == $past(i_writedata[RCC_SPLIT])) else $error("split bit not written");
  chk_uv_gate: assert property (o_undervolt_reset_en |-> i_sbor_allowed)
    else $error("undervoltage enable without permission");
  chk_uv_write: assert property (wr_rcc |=>
    o_undervolt_reset_en == ($past(i_writedata[RCC_SBOR]) && i_sbor_allowed))
    else $error("undervoltage enable not written");
  chk_freq_default: assert property (ev |=> o_fast_osc_freq == FREQ_RST)
    else $error("frequency selection not restored");
  chk_wake_start: assert property ((ev || i_wdt) && i_pm_mode && o_cpu_run |=>
    !o_cpu_run [*8]) else $error("wake did not hold the cpu");
  chk_cpu_min_delay: assert property ($rose(o_cpu_run) |-> !$past(o_cpu_run, 101))
    else $error("cpu released too early");
  chk_slow_no_flag: assert property ($rose(o_cpu_run) && i_src_after == AFT_SLOW |->
    !o_primary_clock_ready && !o_internal_osc_stable) else $error("flag set for slow target");
  cover property ($rose(o_cpu_run));
  cover property ($rose(o_primary_clock_ready));
  cover property (o_irq);
endmodule

/* File: bench/reset_source_model.sv */
`timescale 1ns/1ns
module reset_source_model
  import wake_seq_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_fire,
  input wire cause_t i_kind,
  output logic o_por,
  output logic o_wdt,
  output logic o_bor,
  output logic o_rst_instr,
  output logic o_stack_full,
  output logic o_stack_under,
  output logic o_master_clear_n
);
  int low_left = 0;
  initial begin
    {o_por, o_wdt, o_bor, o_rst_instr, o_stack_full, o_stack_under} = 6'h0;
    o_master_clear_n = 1'b1;
  end
  // Each cause has its own line except the two master clear kinds, which share the pin, so every kind of reset reaches the block on its own.
  always @(posedge i_mclk) begin
    o_por <= i_fire && i_kind == CAUSE_POR;
    o_wdt <= i_fire && i_kind == CAUSE_WDT;
    o_bor <= i_fire && i_kind == CAUSE_BOR;
    o_rst_instr <= i_fire && i_kind == CAUSE_INSTR;
    o_stack_full <= i_fire && i_kind == CAUSE_STK_FULL;
    o_stack_under <= i_fire && i_kind == CAUSE_STK_UNDER;
    // The pin stays low long enough to pass the three-stage input synchroniser.
    if (i_fire && (i_kind == CAUSE_MASTER_CLEAR_PIN_RUN || i_kind == CAUSE_MASTER_CLEAR_PIN_PM)) begin
      low_left <= 8;
    end else if (low_left > 0) begin
      low_left <= low_left - 1;
    end
    o_master_clear_n <= (low_left == 0);
  end
endmodule

/* File: bench/wake_reset_exit_sequencer_tb.sv */
`timescale 1ns/1ns
module wake_reset_exit_sequencer_tb;
  import wake_seq_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic [2:0] i_address = 3'h0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [3:0] i_byteenable = 4'hf;
  logic i_pm_mode = 1'b0;
  src_before_t i_src_before = BEF_PRIMARY_IDLE_MODE;
  src_after_t i_src_after = AFT_EXT;
  logic i_sleep_instr = 1'b0, i_clrwdt = 1'b0, i_sbor_allowed = 1'b1, fire = 1'b0;
  logic i_por, i_wdt, i_bor, i_rst_instr, i_stack_full, i_stack_under, i_master_clear_n;
  logic [31:0] o_readdata, q;
  logic o_waitrequest, o_cpu_run, o_primary_clock_ready, o_internal_osc_stable;
  logic o_irq_level_split, o_undervolt_reset_en, o_irq;
  logic [2:0] o_fast_osc_freq;
  cause_t kind = CAUSE_POR;
  int bad_count = 0;
  int checked = 0;
  int n;
  logic [7:0] exp_rcc [8] = '{8'hdc, 8'hdf, 8'hdf, 8'hd7, 8'hce, 8'hcf, 8'hdf, 8'hdf};
  src_before_t bef [8] = '{BEF_PRIMARY_IDLE_MODE, BEF_SLEEP, BEF_TIMER1, BEF_SLOW, BEF_SLEEP, BEF_FAST,
    BEF_SLEEP, BEF_FAST};
  src_after_t aft [8] = '{AFT_HS, AFT_LP, AFT_PLL, AFT_RC, AFT_FAST, AFT_FAST, AFT_SLOW, AFT_XT};
  int dly [8] = '{100, 1000, 3000, 100, 100, 100, 100, 1000};
  logic [2:0] flg [8] = '{3'h6, 3'h6, 3'h6, 3'h0, 3'h5, 3'h5, 3'h4, 3'h6};
  always #10 i_mclk = ~i_mclk;
  wake_reset_exit_sequencer wake_reset_exit_sequencer_inst (.*);
  reset_source_model reset_source_model_inst (.i_mclk(i_mclk), .i_fire(fire), .i_kind(kind),
    .o_por(i_por), .o_wdt(i_wdt), .o_bor(i_bor), .o_rst_instr(i_rst_instr),
    .o_stack_full(i_stack_full), .o_stack_under(i_stack_under),
    .o_master_clear_n(i_master_clear_n));
  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic give_up();
    bad_count++;
    $display("MISMATCH at %0t: wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge i_mclk);
    i_write <= wr;
    i_read <= !wr;
    i_address <= a;
    i_writedata <= d;
    do begin
      @(posedge i_mclk);
      w++;
    end while (o_waitrequest !== 1'b0 && w < 40);
    if (w >= 40) give_up();
    q = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(q & m, e);
  endtask
  task automatic ev(input cause_t c);
    @(posedge i_mclk);
    fire <= 1'b1;
    kind <= c;
    @(posedge i_mclk);
    fire <= 1'b0;
  endtask
  // Counts the cycles during which the cpu is held, from the cycle after the wake edge.
  task automatic wake_len();
    int g;
    g = 0;
    n = 0;
    while (o_cpu_run !== 1'b0 && g < 40) begin
      @(negedge i_mclk);
      g++;
    end
    while (o_cpu_run === 1'b0 && n < 4000) begin
      @(negedge i_mclk);
      n++;
    end
    if (g >= 40 || n >= 4000) give_up();
    @(posedge i_mclk);
    i_pm_mode <= 1'b0;
    @(negedge i_mclk);
  endtask
  initial begin
    repeat (5) @(posedge i_mclk);
    i_rstn <= 1'b1;
    rd(OFS_RCC, 32'hff, 32'h5c);
    rd(OFS_OSC, 32'h70, 32'h40);
    rd(3'h7, 32'hffffffff, 32'h0);
    bus(1'b1, OFS_RCC, 32'hff);
    rd(OFS_RCC, 32'hff, 32'hdf);
    cmp({o_irq_level_split, o_undervolt_reset_en, o_irq}, 3'h6);
    i_sbor_allowed <= 1'b0;
    @(negedge i_mclk);
    cmp(o_undervolt_reset_en, 1'b0);
    bus(1'b1, OFS_RCC, 32'h0);
    i_sbor_allowed <= 1'b1;
    rd(OFS_RCC, 32'hff, 32'h0c);
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, OFS_RCC, 32'hff);
      bus(1'b1, OFS_OSC, 32'h70);
      @(posedge i_mclk);
      i_clrwdt <= 1'b1;
      i_pm_mode <= (k == 2);
      @(posedge i_mclk);
      i_clrwdt <= 1'b0;
      ev(cause_t'(k));
      if (k == 2) wake_len();
      if (k == 2) cmp(n, 101);
      else repeat (16) @(posedge i_mclk);
      rd(OFS_RCC, 32'hff, exp_rcc[k]);
      rd(OFS_CAUSE, 32'h7, k);
      rd(OFS_STAT, 32'h1 << k, 32'h1 << k);
      rd(OFS_OSC, 32'h70, 32'h40);
    end
    @(posedge i_mclk);
    i_sleep_instr <= 1'b1;
    @(posedge i_mclk);
    i_sleep_instr <= 1'b0;
    rd(OFS_RCC, 32'hff, 32'hdb);
    bus(1'b1, OFS_MASK, 32'h1 << ST_EXIT);
    for (int c = 0; c < 8; c++) begin
      @(posedge i_mclk);
      i_src_before <= bef[c];
      i_src_after <= aft[c];
      i_pm_mode <= 1'b1;
      ev(CAUSE_STK_FULL);
      wake_len();
      cmp(n, dly[c] + 1);
      if (flg[c][2]) cmp({o_primary_clock_ready, o_internal_osc_stable}, flg[c][1:0]);
      rd(OFS_CAUSE, 32'h7, CAUSE_STK_FULL);
      cmp(o_irq, 1'b1);
      if (flg[c][2]) rd(OFS_OSC, 32'hc, {28'h0, flg[c][1:0], 2'b00});
      rd(OFS_STAT, 32'h1 << ST_EXIT, 32'h1 << ST_EXIT);
      @(posedge i_mclk);
      @(negedge i_mclk);
      cmp(o_irq, 1'b0);
    end
    tally_and_finish();
  end
endmodule
bind wake_reset_exit_sequencer wake_seq_checker wake_seq_checker_inst (.*);
